/* scsi_general_cmd_power_ctrl.sv */
// General commands and power management of the SCSI controller core
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
module scsi_general_cmd_power_ctrl
   import scsi_gen_pkg::*;
#(
   parameter longint RST_CYCLES = BUS_RST_CYCLES,
   parameter int FIFO_DEPTH = 16,
   parameter int FIFO_AW = 4
)
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic scsi_bsy_n,
   input wire logic power_down_request_n,
   output logic scsi_rst_o,
   output logic scsi_rst_oe,
   output logic bus_activity_n,
   output logic input_buffer_en,
   output logic core_reset_o,
   output logic irq_o
);
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {ST_DISCONNECTED, ST_CORE_RESET, ST_BUS_RESET} ctl_state_e;

   logic rst_s1_q;
   logic rst_n_q;
   logic bsy_level;
   logic power_down_request_level;
   ctl_state_e state_q;
   logic [31:0] rst_cnt_q;
   logic [7:0] control_one_q;
   logic [7:0] control_four_q;
   logic [23:0] stc_q;
   logic [23:0] ctc_q;
   logic power_down_request_stat_q;
   logic power_down_request_prev_q;
   logic [1:0] irq_stat_q;
   logic [FIFO_AW:0] fifo_bottom_q;
   logic [FIFO_AW-1:0] fifo_top_q;
   logic [7:0] fifo_rd_data;
   logic wr_strobe;
   logic rd_strobe;
   logic cmd_write;
   logic [7:0] cmd_byte;
   logic [31:0] rd_mux;
   logic fifo_push;
   logic fifo_pop;
   logic clear_fifo;
   logic power_down_request_set;

   // Byte-lane write of the low byte
   function automatic logic lane0(input logic [3:0] sel);
      return sel[0];
   endfunction

   // Command decode ignoring the DMA qualifier
   function automatic logic is_cmd(input logic [7:0] b, input logic [6:0] code);
      return b[6:0] == code;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   scsi_sync3 #(.INIT(1'b1)) u_bsy_sync
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n_q),
      .pin(scsi_bsy_n | ~input_buffer_en),
      .level(bsy_level)
   );

   scsi_sync3 #(.INIT(1'b1)) u_power_down_request_sync
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n_q),
      .pin(power_down_request_n),
      .level(power_down_request_level)
   );

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave: one wait state, every address acknowledged
   assign wr_strobe = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign rd_strobe = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   assign cmd_write = wr_strobe && lane0(wb_sel_i) && wb_adr_i == OFF_COMMAND;
   assign cmd_byte = wb_dat_i[7:0];

   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   always_comb
   begin
      rd_mux = UNMAPPED_DATA;
      case (wb_adr_i)
         OFF_STC: rd_mux = {8'h00, stc_q};
         OFF_CTC: rd_mux = {8'h00, ctc_q};
         OFF_FIFO_DATA: rd_mux = {24'h000000, fifo_rd_data};
         OFF_FIFO_STATUS: rd_mux = {27'h0, fifo_bottom_q};
         OFF_CONTROL_ONE: rd_mux = {24'h000000, control_one_q};
         OFF_CONTROL_FOUR: rd_mux = {24'h000000, control_four_q};
         OFF_DMA_STATUS: rd_mux = {31'h0, power_down_request_stat_q};
         OFF_IRQ_STATUS: rd_mux = {30'h0, irq_stat_q};
         OFF_BUS_STATE: rd_mux = {29'h0, ~bsy_level, state_q};
         default: rd_mux = UNMAPPED_DATA;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         wb_dat_o <= 32'h00000000;
      end
      else if (rd_strobe)
      begin
         wb_dat_o <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command sequencer
   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         state_q <= ST_DISCONNECTED;
         rst_cnt_q <= 32'h00000000;
      end
      else
      begin
         case (state_q)
            ST_DISCONNECTED:
            begin
               if (cmd_write && is_cmd(cmd_byte, CMD_RESET_DEVICE))
               begin
                  state_q <= ST_CORE_RESET;
               end
               else if (cmd_write && is_cmd(cmd_byte, CMD_RESET_BUS))
               begin
                  state_q <= ST_BUS_RESET;
                  rst_cnt_q <= 32'(RST_CYCLES - 1);
               end
            end
            ST_CORE_RESET:
            begin
               // Only a no-operation releases the held reset
               if (cmd_write && is_cmd(cmd_byte, CMD_NOP))
               begin
                  state_q <= ST_DISCONNECTED;
               end
            end
            ST_BUS_RESET:
            begin
               // A device reset cuts a running bus reset short
               if (cmd_write && is_cmd(cmd_byte, CMD_RESET_DEVICE))
               begin
                  state_q <= ST_CORE_RESET;
               end
               else if (rst_cnt_q == 32'h00000000)
               begin
                  state_q <= ST_DISCONNECTED;
               end
               else
               begin
                  rst_cnt_q <= rst_cnt_q - 32'h00000001;
               end
            end
            default: state_q <= ST_DISCONNECTED;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         scsi_rst_o <= 1'b0;
         scsi_rst_oe <= 1'b0;
         core_reset_o <= 1'b0;
      end
      else
      begin
         scsi_rst_o <= 1'b0;
         scsi_rst_oe <= state_q == ST_BUS_RESET;
         core_reset_o <= state_q == ST_CORE_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers; a device reset returns them to reset values
   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         control_one_q <= CONTROL_ONE_RESET;
         control_four_q <= CONTROL_FOUR_RESET;
         stc_q <= STC_RESET;
         ctc_q <= STC_RESET;
      end
      else if (state_q == ST_CORE_RESET)
      begin
         control_one_q <= CONTROL_ONE_RESET;
         control_four_q <= CONTROL_FOUR_RESET;
         stc_q <= STC_RESET;
         ctc_q <= STC_RESET;
      end
      else
      begin
         if (wr_strobe && lane0(wb_sel_i) && wb_adr_i == OFF_CONTROL_ONE)
         begin
            control_one_q <= wb_dat_i[7:0];
         end
         if (wr_strobe && lane0(wb_sel_i) && wb_adr_i == OFF_CONTROL_FOUR)
         begin
            control_four_q <= wb_dat_i[7:0];
         end
         if (wr_strobe && wb_adr_i == OFF_STC)
         begin
            stc_q <= wb_dat_i[23:0];
         end
         // DMA qualified no-operation loads the current count
         if (cmd_write && cmd_byte[CMD_DMA_BIT] && is_cmd(cmd_byte, CMD_NOP))
         begin
            ctc_q <= stc_q;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         input_buffer_en <= 1'b1;
         bus_activity_n <= 1'b1;
      end
      else
      begin
         input_buffer_en <= !control_four_q[CTL4_INBUF_OFF_BIT];
         bus_activity_n <= bsy_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // SCSI FIFO
   assign clear_fifo = (cmd_write && is_cmd(cmd_byte, CMD_CLEAR_FIFO)) || state_q == ST_CORE_RESET;
   assign fifo_push = wr_strobe && wb_adr_i == OFF_FIFO_DATA && fifo_bottom_q != FIFO_DEPTH;
   assign fifo_pop = rd_strobe && wb_adr_i == OFF_FIFO_DATA && fifo_bottom_q != '0;

   scsi_fifo_mem #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo
   (
      .sys_clk(sys_clk),
      .wr_en(fifo_push),
      .wr_addr(FIFO_AW'(fifo_top_q + fifo_bottom_q[FIFO_AW-1:0])),
      .wr_data(wb_dat_i[7:0]),
      .rd_addr(fifo_top_q),
      .rd_data(fifo_rd_data)
   );

   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         fifo_bottom_q <= '0;
         fifo_top_q <= '0;
      end
      else if (clear_fifo)
      begin
         fifo_bottom_q <= '0;
         fifo_top_q <= '0;
      end
      else
      begin
         if (fifo_push && !fifo_pop)
         begin
            fifo_bottom_q <= fifo_bottom_q + 1'b1;
         end
         else if (fifo_pop && !fifo_push)
         begin
            fifo_bottom_q <= fifo_bottom_q - 1'b1;
         end
         if (fifo_pop)
         begin
            fifo_top_q <= fifo_top_q + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power-down status and interrupt flags; set beats a same-cycle clear
   assign power_down_request_set = !power_down_request_level && power_down_request_prev_q;

   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         power_down_request_prev_q <= 1'b1;
         power_down_request_stat_q <= 1'b0;
         irq_stat_q <= 2'h0;
      end
      else
      begin
         power_down_request_prev_q <= power_down_request_level;
         if (power_down_request_set)
         begin
            power_down_request_stat_q <= 1'b1;
         end
         else if (wr_strobe && wb_adr_i == OFF_DMA_STATUS && wb_dat_i[DMA_STAT_POWER_DOWN_REQUEST_BIT])
         begin
            power_down_request_stat_q <= 1'b0;
         end
         // Only the 0-to-1 move of the status bit interrupts
         if (power_down_request_set && !power_down_request_stat_q)
         begin
            irq_stat_q[IRQ_POWER_DOWN_REQUEST_BIT] <= 1'b1;
         end
         else if (wr_strobe && wb_adr_i == OFF_IRQ_STATUS && wb_dat_i[IRQ_POWER_DOWN_REQUEST_BIT])
         begin
            irq_stat_q[IRQ_POWER_DOWN_REQUEST_BIT] <= 1'b0;
         end
         // Bus reset: no completion event, only the bus-reset one
         if (cmd_write && is_cmd(cmd_byte, CMD_RESET_BUS) && state_q == ST_DISCONNECTED
             && !control_one_q[CTL1_RST_IRQ_DIS_BIT])
         begin
            irq_stat_q[IRQ_BUS_RST_BIT] <= 1'b1;
         end
         else if (wr_strobe && wb_adr_i == OFF_IRQ_STATUS && wb_dat_i[IRQ_BUS_RST_BIT])
         begin
            irq_stat_q[IRQ_BUS_RST_BIT] <= 1'b0;
         end
      end
   end

   // No-operation and clear-FIFO touch no interrupt flag
   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         irq_o <= 1'b0;
      end
      else
      begin
         irq_o <= |irq_stat_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence bus_rst_cmd_s;
      cmd_write && is_cmd(cmd_byte, CMD_RESET_BUS) && state_q == ST_DISCONNECTED;
   endsequence

   sequence rst_drive_s;
      ##2 scsi_rst_oe;
   endsequence

   bus_rst_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      bus_rst_cmd_s |-> rst_drive_s)
      else $error("bus reset not driven");

   core_rst_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      (state_q == ST_CORE_RESET && !(cmd_write && is_cmd(cmd_byte, CMD_NOP)))
      |=> state_q == ST_CORE_RESET)
      else $error("core reset released without nop");

   core_rst_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      (cmd_write && is_cmd(cmd_byte, CMD_RESET_DEVICE) && state_q != ST_CORE_RESET)
      |-> ##2 core_reset_o)
      else $error("device reset not raised");

   dma_nop_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      (cmd_write && cmd_byte == 8'h80 && state_q != ST_CORE_RESET) |=> ctc_q == $past(stc_q))
      else $error("current count not loaded");

   fifo_clear_empty_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      clear_fifo |=> fifo_bottom_q == '0)
      else $error("fifo not empty after clear");

   nop_quiet_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      (cmd_write && is_cmd(cmd_byte, CMD_NOP) && !power_down_request_set)
      |=> $stable(irq_stat_q) || !(|irq_stat_q))
      else $error("nop raised interrupt");

   inbuf_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      control_four_q[CTL4_INBUF_OFF_BIT] |=> !input_buffer_en)
      else $error("input buffers left on");

   power_down_request_status_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      power_down_request_set |=> power_down_request_stat_q)
      else $error("power down status not set");

   power_down_request_irq_once_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      (power_down_request_set && power_down_request_stat_q) |=> irq_stat_q[IRQ_POWER_DOWN_REQUEST_BIT] == $past(irq_stat_q[IRQ_POWER_DOWN_REQUEST_BIT])
      || !irq_stat_q[IRQ_POWER_DOWN_REQUEST_BIT])
      else $error("repeated power down interrupt");

   activity_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      ##1 bus_activity_n == $past(bsy_level))
      else $error("activity output not following busy");
endmodule

/* scsi_gen_pkg.sv */
// Package of constants for the SCSI general command and power control block
package scsi_gen_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_COMMAND = 8'h0C;
   localparam logic [7:0] OFF_STC = 8'h00;
   localparam logic [7:0] OFF_CTC = 8'h04;
   localparam logic [7:0] OFF_FIFO_DATA = 8'h08;
   localparam logic [7:0] OFF_FIFO_STATUS = 8'h1C;
   localparam logic [7:0] OFF_CONTROL_ONE = 8'h20;
   localparam logic [7:0] OFF_CONTROL_FOUR = 8'h34;
   localparam logic [7:0] OFF_DMA_STATUS = 8'h54;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
   localparam logic [7:0] OFF_BUS_STATE = 8'h18;
   // Command codes (bit 7 is the DMA qualifier)
   localparam logic [6:0] CMD_NOP = 7'h00;
   localparam logic [6:0] CMD_CLEAR_FIFO = 7'h01;
   localparam logic [6:0] CMD_RESET_DEVICE = 7'h02;
   localparam logic [6:0] CMD_RESET_BUS = 7'h03;
   localparam int CMD_DMA_BIT = 7;
   // Field positions
   localparam int CTL1_RST_IRQ_DIS_BIT = 6;
   localparam int CTL4_INBUF_OFF_BIT = 5;
   localparam int DMA_STAT_POWER_DOWN_REQUEST_BIT = 0;
   localparam int IRQ_POWER_DOWN_REQUEST_BIT = 0;
   localparam int IRQ_BUS_RST_BIT = 1;
   // Reset values
   localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
   localparam logic [7:0] CONTROL_FOUR_RESET = 8'h00;
   localparam logic [23:0] STC_RESET = 24'h000000;
   // Timing
   localparam longint CLK_HZ = 200000000;
   localparam longint BUS_RST_MS = 25;
   localparam longint BUS_RST_CYCLES = (BUS_RST_MS * CLK_HZ) / 1000;
   // Unmapped reads answer with this
   localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage

/* scsi_fifo_mem.sv */
// Small SCSI data FIFO memory with registered read data
`timescale 1ns/100ps
module scsi_fifo_mem
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW = 4
)
(
   input wire logic sys_clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge sys_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

/* scsi_sync3.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module scsi_sync3
#(
   parameter logic INIT = 1'b0
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // Level only moves once stages two and three agree
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         level <= INIT;
      end
      else
      begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
         begin
            level <= s3_q;
         end
      end
   end
endmodule

/* scsi_far_side.sv */
// Behavioural SCSI bus target and outside power watcher facing the block
`timescale 1ns/100ps
module scsi_far_side
#(
   parameter int FREE_CYCLES = 40
)
(
   input wire logic sys_clk,
   input wire logic busy_req,
   input wire logic scsi_rst_o,
   input wire logic scsi_rst_oe,
   input wire logic bus_activity_n,
   output logic scsi_bsy_n,
   output logic bus_free
);
   logic rst_wire_n;
   int quiet_q = 0;
   // Terminators pull RST high while nobody drives it
   assign rst_wire_n = scsi_rst_oe ? scsi_rst_o : 1'h1;
   ////////////////////////////////////////////////////////////////////////////////
   // A target lets go of BSY during a bus reset; the released line goes to its pull-up
   always @(posedge sys_clk)
   begin
      scsi_bsy_n <= !(busy_req && rst_wire_n);
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Bus is free only once activity has stayed off for the whole quiet window
   always @(posedge sys_clk)
   begin
      if (bus_activity_n !== 1'h1)
         quiet_q <= 0;
      else if (quiet_q < FREE_CYCLES)
         quiet_q <= quiet_q + 1;
   end
   assign bus_free = (quiet_q >= FREE_CYCLES);
endmodule

/* testbench.sv */
// Self-checking bench for the SCSI general command and power control block
`timescale 1ns/100ps
module testbench;
   import scsi_gen_pkg::*;
   localparam int RCY = 20;
   localparam int W_RST = 0;
   localparam int W_CORE = 1;
   localparam int W_ACT = 2;
   localparam int W_IRQ = 3;
   localparam int W_BUF = 4;
   logic sys_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [3:0] wb_sel_i;
   logic scsi_bsy_n, power_down_request_n, scsi_rst_o, scsi_rst_oe, bus_activity_n;
   logic input_buffer_en, core_reset_o, irq_o, busy_req, bus_free;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int len;

   scsi_general_cmd_power_ctrl #(.RST_CYCLES(RCY)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .scsi_bsy_n(scsi_bsy_n), .power_down_request_n(power_down_request_n),
      .scsi_rst_o(scsi_rst_o), .scsi_rst_oe(scsi_rst_oe), .bus_activity_n(bus_activity_n),
      .input_buffer_en(input_buffer_en), .core_reset_o(core_reset_o), .irq_o(irq_o));
   scsi_far_side #(.FREE_CYCLES(40)) far (.sys_clk(sys_clk), .busy_req(busy_req),
      .scsi_rst_o(scsi_rst_o), .scsi_rst_oe(scsi_rst_oe), .bus_activity_n(bus_activity_n),
      .scsi_bsy_n(scsi_bsy_n), .bus_free(bus_free));

   initial
   begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
   begin
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask

   // Whole run needs a few hundred cycles; a hang ends here
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count = bad_count + 1;
         complete_run();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
   begin
      comparisons++;
      if (seen !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, seen);
         bad_count++;
      end
   end
   endtask

   // One classic cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int k;
   begin
      @(posedge sys_clk);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      k = 0;
      do
      begin
         @(posedge sys_clk);
         k++;
      end
      while (wb_ack_o !== 1'h1 && k < 20);
      check("wb_ack_o", {31'h0, wb_ack_o}, 32'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   end
   endtask

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
   begin
      wb(1'h0, a, 32'h0);
      check(what, rd, exp);
   end
   endtask

   function automatic logic pick(input int w);
      case (w)
         W_RST: return scsi_rst_oe;
         W_CORE: return core_reset_o;
         W_ACT: return bus_activity_n;
         W_IRQ: return irq_o;
         default: return input_buffer_en;
      endcase
   endfunction

   // Synchroniser and register stages make the delay a few cycles, so wait bounded
   task automatic await(input string what, input int w, input logic v);
      int k;
   begin
      k = 0;
      while (pick(w) !== v && k < 12)
      begin
         @(posedge sys_clk);
         k++;
      end
      check(what, {31'h0, pick(w)}, {31'h0, v});
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      reset_n = 1'h0;
      wb_cyc_i = 1'h0;
      wb_stb_i = 1'h0;
      wb_we_i = 1'h0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'h0;
      power_down_request_n = 1'h1;
      busy_req = 1'h0;
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'h1;
      repeat (4) @(posedge sys_clk);
      check("idle outputs", {27'h0, scsi_rst_oe, bus_activity_n, input_buffer_en,
         core_reset_o, irq_o}, 32'h0000000C);
      rdchk("control_four", OFF_CONTROL_FOUR, {24'h0, CONTROL_FOUR_RESET});
      rdchk("dma_status", OFF_DMA_STATUS, 32'h0);
      wb(1'h1, 8'h40, 32'h000000A5);
      rdchk("unmapped", 8'h40, UNMAPPED_DATA);
      $display("test registers done");

      wb(1'h1, OFF_STC, 32'h00ABCDEF);
      wb(1'h1, OFF_COMMAND, {24'h0, 1'h1, CMD_NOP});
      rdchk("current count", OFF_CTC, 32'h00ABCDEF);
      wb(1'h1, OFF_COMMAND, {24'h0, 1'h0, CMD_NOP});
      repeat (3) @(posedge sys_clk);
      check("irq after nop", {31'h0, irq_o}, 32'h0);
      $display("test no operation done");

      for (int i = 0; i < 3; i++)
         wb(1'h1, OFF_FIFO_DATA, 32'h5A + i);
      rdchk("fifo count", OFF_FIFO_STATUS, 32'h3);
      wb(1'h1, OFF_COMMAND, {25'h0, CMD_CLEAR_FIFO});
      rdchk("fifo count", OFF_FIFO_STATUS, 32'h0);
      check("irq after clear", {31'h0, irq_o}, 32'h0);
      $display("test clear fifo done");

      wb(1'h1, OFF_CONTROL_ONE, 32'h0);
      busy_req <= 1'h1;
      await("activity on", W_ACT, 1'h0);
      wb(1'h1, OFF_COMMAND, {25'h0, CMD_RESET_BUS});
      await("rst driven", W_RST, 1'h1);
      len = 0;
      while (scsi_rst_oe === 1'h1 && len < RCY + 10)
      begin
         @(posedge sys_clk);
         len++;
      end
      check("rst length", len, RCY);
      check("rst level", {31'h0, scsi_rst_o}, 32'h0);
      await("activity off", W_ACT, 1'h1);
      check("bus reset irq", {31'h0, irq_o}, 32'h1);
      rdchk("irq status", OFF_IRQ_STATUS, 32'h1 << IRQ_BUS_RST_BIT);
      wb(1'h1, OFF_IRQ_STATUS, 32'h1 << IRQ_BUS_RST_BIT);
      await("irq cleared", W_IRQ, 1'h0);
      wb(1'h1, OFF_CONTROL_ONE, 32'h1 << CTL1_RST_IRQ_DIS_BIT);
      wb(1'h1, OFF_COMMAND, {25'h0, CMD_RESET_BUS});
      await("rst driven", W_RST, 1'h1);
      repeat (RCY + 4) @(posedge sys_clk);
      check("masked irq", {30'h0, scsi_rst_oe, irq_o}, 32'h0);
      rdchk("irq status", OFF_IRQ_STATUS, 32'h0);
      busy_req <= 1'h0;
      $display("test bus reset done");

      // Reduced power is entered only once the bus has been quiet long enough
      len = 0;
      while (bus_free !== 1'h1 && len < 100)
      begin
         @(posedge sys_clk);
         len++;
      end
      check("bus free", {31'h0, bus_free}, 32'h1);
      wb(1'h1, OFF_CONTROL_FOUR, 32'h1 << CTL4_INBUF_OFF_BIT);
      await("buffers off", W_BUF, 1'h0);
      busy_req <= 1'h1;
      repeat (8) @(posedge sys_clk);
      check("gated activity", {31'h0, bus_activity_n}, 32'h1);
      busy_req <= 1'h0;
      // Device reset issued while a bus reset is still running
      wb(1'h1, OFF_COMMAND, {25'h0, CMD_RESET_BUS});
      wb(1'h1, OFF_COMMAND, {25'h0, CMD_RESET_DEVICE});
      await("core reset", W_CORE, 1'h1);
      check("bus reset cut", {31'h0, scsi_rst_oe}, 32'h0);
      wb(1'h1, OFF_COMMAND, {25'h0, CMD_CLEAR_FIFO});
      repeat (4) @(posedge sys_clk);
      check("core held", {31'h0, core_reset_o}, 32'h1);
      wb(1'h1, OFF_COMMAND, {25'h0, CMD_NOP});
      await("core released", W_CORE, 1'h0);
      await("buffers on", W_BUF, 1'h1);
      rdchk("control_four", OFF_CONTROL_FOUR, 32'h0);
      rdchk("control_one", OFF_CONTROL_ONE, {24'h0, CONTROL_ONE_RESET});
      $display("test device reset done");

      power_down_request_n <= 1'h0;
      await("power irq", W_IRQ, 1'h1);
      rdchk("dma_status", OFF_DMA_STATUS, 32'h1 << DMA_STAT_POWER_DOWN_REQUEST_BIT);
      wb(1'h1, OFF_IRQ_STATUS, 32'h1 << IRQ_POWER_DOWN_REQUEST_BIT);
      await("power irq clear", W_IRQ, 1'h0);
      repeat (10) @(posedge sys_clk);
      check("no repeat irq", {31'h0, irq_o}, 32'h0);
      power_down_request_n <= 1'h1;
      $display("test power down done");
      complete_run();
   end
endmodule
